/* File: rtl/fpes_pkg.sv */
// package: constants, types and carriers of the flash program/erase sequencer
package fpes_pkg;
    // core clock rate, used to turn times into cycle counts
    localparam int CORE_CLK_MHZ = 40;
    // page geometry and address layout
    localparam int PAGE_BYTES = 256;
    localparam int ADDR_BITS  = 24;
    localparam int SECT_LSB   = 16;   // 64 KB sectors
    localparam int SECT_BITS  = 6;
    // fixed opcodes of the latch commands
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    // default opcodes of program and erase commands (arbitrary, overridable)
    localparam logic [7:0] OP_PP_DEF  = 8'h10;
    localparam logic [7:0] OP_DP_DEF  = 8'h11;
    localparam logic [7:0] OP_DPX_DEF = 8'h12;
    localparam logic [7:0] OP_QP_DEF  = 8'h13;
    localparam logic [7:0] OP_QPX_DEF = 8'h14;
    localparam logic [7:0] OP_SSE_DEF = 8'h15;
    localparam logic [7:0] OP_SE_DEF  = 8'h16;
    // byte counts of a frame: command, command + three address bytes, first data byte, saturation
    localparam logic [2:0] NB_CMD  = 3'h1;
    localparam logic [2:0] NB_ADDR = 3'h4;
    localparam logic [2:0] NB_DATA = 3'h5;
    localparam logic [2:0] NB_SAT  = 3'h7;
    // status and flag bit positions
    localparam int SR_WIP    = 0;
    localparam int SR_WEL    = 1;
    localparam int FSR_PROT  = 1;
    localparam int FSR_PGM   = 4;
    localparam int FSR_ERS   = 5;
    localparam int FSR_READY = 7;
    // default self-timed durations in microseconds (plain values)
    localparam int PROGRAM_DURATION_US_DEF           = 500;
    localparam int SMALL_BLOCK_ERASE_DURATION_US_DEF = 50000;
    localparam int BLOCK_ERASE_DURATION_US_DEF       = 400000;
    // line protocol
    typedef enum logic [1:0] {
        PROTO_EXT  = 2'h0,
        PROTO_DUAL = 2'h1,
        PROTO_QUAD = 2'h2
    } fpes_proto_t;
    // kind of array operation
    typedef enum logic [1:0] {
        OPK_PROG = 2'h0,
        OPK_SSE  = 2'h1,
        OPK_SE   = 2'h2
    } fpes_kind_t;
    // operation handed to the array
    typedef struct packed {
        fpes_kind_t             kind;
        logic [ADDR_BITS-1:0]   addr;
    } fpes_op_t;
    // sequencer state
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_BUSY = 1'b1
    } fpes_state_t;
endpackage

/* File: rtl/fpes_seq.sv */
// module: program/erase/write-enable sequencer behind a serial flash link
`timescale 1ns/100ps
//
// Notes on behaviour
// - program starts when select rises after last byte
// - opcode, address, then at least one data byte
// - unaligned start wraps data within its page
// - excess bytes overwrite earlier ones, last page kept
// - short data leaves other page bytes untouched
// - busy flag during operation, latch cleared
// - program timeout clears latch, sets program fail
// - select rising at wrong point executes nothing
// - locked program refused, flags 1 and 4
// - dual variants: two data lines, ext/dual only
// - quad variants: four data lines, ext/quad only
// - command/address cycles scale with line count
// - latch commands are exactly eight bits
// - latch must be set before program or erase
// - unfinished enable leaves latch at zero
// - disable clears latch; unfinished one keeps it
// - 06h enables, 04h disables the latch
// - subsector erase: opcode plus three address bytes
// - sector erase: opcode plus three address bytes
// - erase without latch ignored, no flags
// - erase timeout clears latch, sets erase error
// - locked erase refused, flags 1 and 5
// - addresses are 24 bits, three bytes
module fpes_seq #(
    parameter logic [7:0] OP_PP  = fpes_pkg::OP_PP_DEF,
    parameter logic [7:0] OP_DP  = fpes_pkg::OP_DP_DEF,
    parameter logic [7:0] OP_DPX = fpes_pkg::OP_DPX_DEF,
    parameter logic [7:0] OP_QP  = fpes_pkg::OP_QP_DEF,
    parameter logic [7:0] OP_QPX = fpes_pkg::OP_QPX_DEF,
    parameter logic [7:0] OP_SSE = fpes_pkg::OP_SSE_DEF,
    parameter logic [7:0] OP_SE  = fpes_pkg::OP_SE_DEF,
    parameter int PROGRAM_DURATION_US           = fpes_pkg::PROGRAM_DURATION_US_DEF,
    parameter int SMALL_BLOCK_ERASE_DURATION_US = fpes_pkg::SMALL_BLOCK_ERASE_DURATION_US_DEF,
    parameter int BLOCK_ERASE_DURATION_US       = fpes_pkg::BLOCK_ERASE_DURATION_US_DEF
) (
    // core clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     resetn_i,
    // serial link from the host
    input  wire logic                     sclk_i,
    input  wire logic                     cs_n_i,
    input  wire logic [3:0]               dq_i,
    // configuration and control
    input  wire fpes_pkg::fpes_proto_t    proto_i,
    input  wire logic [63:0]              lock_sector_i,
    input  wire logic                     flag_clear_i,
    input  wire logic                     array_fail_i,
    input  wire logic [7:0]               page_idx_i,
    // status
    output logic [7:0]                    status_o,
    output logic [7:0]                    flags_o,
    output logic                          busy_o,
    output logic                          suspendable_o,
    // array operation
    output logic                          op_start_o,
    output fpes_pkg::fpes_op_t            op_o,
    output logic [7:0]                    page_byte_o,
    output logic                          page_keep_o
);
    localparam int PROG_CYC = PROGRAM_DURATION_US * fpes_pkg::CORE_CLK_MHZ;
    localparam int SSE_CYC  = SMALL_BLOCK_ERASE_DURATION_US * fpes_pkg::CORE_CLK_MHZ;
    localparam int SE_CYC   = BLOCK_ERASE_DURATION_US * fpes_pkg::CORE_CLK_MHZ;

    // lines per clock edge for a protocol
    function automatic logic [3:0] lanes_of(input fpes_pkg::fpes_proto_t p);
        case (p)
            fpes_pkg::PROTO_DUAL: lanes_of = 4'h2;
            fpes_pkg::PROTO_QUAD: lanes_of = 4'h4;
            default:              lanes_of = 4'h1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // link domain: shift bytes in on the host clock
    logic                          lrst;        // core-made clear for link flops
    fpes_pkg::fpes_proto_t         proto_l1;    // protocol synchroniser, stage 1
    fpes_pkg::fpes_proto_t         proto_l2;    // protocol synchroniser, stage 2
    logic                          fresh;       // no edge yet in this frame
    logic                          link_tog;    // flips once per frame
    logic [3:0]                    bitpos;      // bits of current byte
    logic [2:0]                    nbytes;      // whole bytes, saturating
    logic [7:0]                    sh;          // partial byte
    logic [7:0]                    opcode;      // first byte
    logic [23:0]                   addr;        // address bytes
    logic [7:0]                    col;         // page column pointer
    logic [7:0]                    lbuf [fpes_pkg::PAGE_BYTES];
    logic [fpes_pkg::PAGE_BYTES-1:0] lmask;     // columns written this frame
    logic [3:0]                    cur_pos;
    logic [2:0]                    cur_nb;
    logic [3:0]                    lw;
    logic [3:0]                    pos_sum;
    logic [7:0]                    nb;
    logic                          byte_done;

    // protocol is quasi-static; settles within two host clock edges
    always_ff @(posedge sclk_i or posedge lrst) begin
        if (lrst) begin
            proto_l1 <= fpes_pkg::PROTO_EXT;
            proto_l2 <= fpes_pkg::PROTO_EXT;
        end else begin
            proto_l1 <= proto_i;
            proto_l2 <= proto_l1;
        end
    end

    // select high marks the next edge as first of a frame; reset covers a
    // select that was already high before this process first waited
    always_ff @(posedge sclk_i or posedge cs_n_i or posedge lrst) begin
        if (cs_n_i || lrst) begin
            fresh <= 1'b1;
        end else begin
            fresh <= 1'b0;
        end
    end

    // frame marker for the core: edges were seen in this frame
    always_ff @(posedge sclk_i or posedge lrst) begin
        if (lrst) begin
            link_tog <= 1'b0;
        end else if (fresh) begin
            link_tog <= ~link_tog;
        end
    end

    // lane width of the current phase
    always_comb begin
        cur_pos = fresh ? 4'h0 : bitpos;
        cur_nb  = fresh ? 3'h0 : nbytes;
        lw      = lanes_of(proto_l2);
        if (cur_nb != 3'h0) begin
            if (opcode == OP_DPX || (cur_nb >= fpes_pkg::NB_ADDR && opcode == OP_DP)) begin
                lw = 4'h2;
            end else if (opcode == OP_QPX ||
                         (cur_nb >= fpes_pkg::NB_ADDR && opcode == OP_QP)) begin
                lw = 4'h4;
            end
        end
        pos_sum   = cur_pos + lw;
        byte_done = (pos_sum == 4'h8);
        // msb first; line zero carries the lowest bit of each group
        case (lw)
            4'h4:    nb = {sh[3:0], dq_i[3:0]};
            4'h2:    nb = {sh[5:0], dq_i[1:0]};
            default: nb = {sh[6:0], dq_i[0]};
        endcase
    end

    // bit and byte counters, restarted by the first edge of a frame
    always_ff @(posedge sclk_i) begin
        bitpos <= byte_done ? 4'h0 : pos_sum;
        sh     <= nb;
        if (byte_done && cur_nb != fpes_pkg::NB_SAT) begin
            nbytes <= cur_nb + 3'h1;
        end else begin
            nbytes <= cur_nb;
        end
    end

    // opcode, address and column capture
    always_ff @(posedge sclk_i) begin
        if (byte_done) begin
            case (cur_nb)
                3'h0: begin
                    opcode <= nb;
                end
                3'h1, 3'h2: begin
                    addr <= {addr[15:0], nb};
                end
                3'h3: begin
                    addr <= {addr[15:0], nb};
                    col  <= nb;                 // start column
                end
                default: begin
                    col <= col + 8'h01;
                end
            endcase
        end
    end

    // page buffer: later bytes overwrite earlier ones at the same column
    always_ff @(posedge sclk_i) begin
        if (byte_done && cur_nb >= fpes_pkg::NB_ADDR) begin
            lbuf[col] <= nb;
        end
    end

    // written-column mask, cleared at frame start
    always_ff @(posedge sclk_i) begin
        if (fresh) begin
            lmask <= '0;
        end else if (byte_done && cur_nb >= fpes_pkg::NB_ADDR) begin
            lmask[col] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core domain: frame end detection
    logic cs_s1;     // select synchroniser, stage 1
    logic cs_s2;     // select synchroniser, stage 2
    logic cs_d;      // previous synchronised select
    logic tog_s1;    // frame marker synchroniser, stage 1
    logic tog_s2;    // frame marker synchroniser, stage 2
    logic tog_seen;  // last marker consumed
    logic frame_end; // select rose after a frame with edges

    // reset request for link flops, held while core reset is low
    always_ff @(posedge core_clk_i) begin
        lrst <= ~resetn_i;
    end

    // synchronisers; link registers are stable once select is high
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cs_s1    <= 1'b1;
            cs_s2    <= 1'b1;
            cs_d     <= 1'b1;
            tog_s1   <= 1'b0;
            tog_s2   <= 1'b0;
            tog_seen <= 1'b0;
        end else begin
            cs_s1 <= cs_n_i;
            cs_s2 <= cs_s1;
            cs_d  <= cs_s2;
            tog_s1 <= link_tog;
            tog_s2 <= tog_s1;
            if (cs_s2 && !cs_d) begin
                tog_seen <= tog_s2;
            end
        end
    end

    assign frame_end = cs_s2 && !cs_d && (tog_s2 != tog_seen);

    ////////////////////////////////////////////////////////////////////////////
    // command decode at frame end
    fpes_pkg::fpes_state_t state;
    logic        wel;        // write enable latch
    logic        prot_err;   // protection error flag
    logic        pgm_err;    // program fail flag
    logic        ers_err;    // erase error flag
    logic [31:0] cnt;        // remaining busy cycles
    logic        byte_ok, is_dp, is_qp, is_prog, is_erase, locked;
    logic        cmd_wren, cmd_wrdi, prog_req, erase_req, prog_go, erase_go;
    logic        prot_hit, done, busy;

    always_comb begin
        busy     = (state == fpes_pkg::ST_BUSY);
        byte_ok  = (bitpos == 4'h0);
        is_dp    = (opcode == OP_DP) || (opcode == OP_DPX);
        is_qp    = (opcode == OP_QP) || (opcode == OP_QPX);
        is_prog  = (opcode == OP_PP) ||
                   (is_dp && proto_i != fpes_pkg::PROTO_QUAD) ||
                   (is_qp && proto_i != fpes_pkg::PROTO_DUAL);
        is_erase = (opcode == OP_SSE) || (opcode == OP_SE);
        locked   = lock_sector_i[addr[fpes_pkg::SECT_LSB +: fpes_pkg::SECT_BITS]];
        cmd_wren = frame_end && byte_ok && !busy && opcode == fpes_pkg::OP_WREN &&
                   nbytes == fpes_pkg::NB_CMD;
        cmd_wrdi = frame_end && byte_ok && !busy && opcode == fpes_pkg::OP_WRDI &&
                   nbytes == fpes_pkg::NB_CMD;
        // program needs opcode, address and data; erase exactly opcode and address
        prog_req  = frame_end && byte_ok && !busy && is_prog && wel &&
                    nbytes >= fpes_pkg::NB_DATA;
        erase_req = frame_end && byte_ok && !busy && is_erase && wel &&
                    nbytes == fpes_pkg::NB_ADDR;
        prot_hit = (prog_req || erase_req) && locked;
        prog_go  = prog_req && !locked;
        erase_go = erase_req && !locked;
        done     = busy && (cnt == 32'h1);
    end

    // sequencer state and self-timed countdown
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            state <= fpes_pkg::ST_IDLE;
            cnt   <= 32'h0;
        end else begin
            case (state)
                fpes_pkg::ST_IDLE: begin
                    if (prog_go) begin
                        state <= fpes_pkg::ST_BUSY;
                        cnt   <= 32'(PROG_CYC);
                    end else if (erase_go) begin
                        state <= fpes_pkg::ST_BUSY;
                        cnt   <= (opcode == OP_SSE) ? 32'(SSE_CYC) : 32'(SE_CYC);
                    end
                end
                fpes_pkg::ST_BUSY: begin
                    cnt <= cnt - 32'h1;
                    if (done) begin
                        state <= fpes_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= fpes_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // write enable latch; refused or unfinished frames leave it alone
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            wel <= 1'b0;
        end else if (cmd_wren) begin
            wel <= 1'b1;
        end else if (cmd_wrdi || prog_go || erase_go || done) begin
            wel <= 1'b0;
        end
    end

    // sticky error flags; a new event wins over a clear
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            prot_err <= 1'b0;
            pgm_err  <= 1'b0;
            ers_err  <= 1'b0;
        end else begin
            if (prot_hit) begin
                prot_err <= 1'b1;
            end else if (flag_clear_i) begin
                prot_err <= 1'b0;
            end
            if ((prot_hit && prog_req) ||
                (done && array_fail_i && op_o.kind == fpes_pkg::OPK_PROG)) begin
                pgm_err <= 1'b1;
            end else if (flag_clear_i) begin
                pgm_err <= 1'b0;
            end
            if ((prot_hit && erase_req) ||
                (done && array_fail_i && op_o.kind != fpes_pkg::OPK_PROG)) begin
                ers_err <= 1'b1;
            end else if (flag_clear_i) begin
                ers_err <= 1'b0;
            end
        end
    end

    // operation descriptor and start pulse toward the array
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            op_start_o <= 1'b0;
            op_o       <= '0;
        end else begin
            op_start_o <= prog_go || erase_go;
            if (prog_go) begin
                op_o <= '{kind: fpes_pkg::OPK_PROG, addr: addr};
            end else if (erase_go) begin
                op_o <= '{kind: (opcode == OP_SSE) ? fpes_pkg::OPK_SSE : fpes_pkg::OPK_SE,
                          addr: addr};
            end
        end
    end

    // page image captured at start; host may send new frames meanwhile
    logic [7:0]                      pbuf [fpes_pkg::PAGE_BYTES];
    logic [fpes_pkg::PAGE_BYTES-1:0] pmask;
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pmask <= '0;
        end else if (prog_go) begin
            pmask <= lmask;
        end
    end
    always_ff @(posedge core_clk_i) begin
        if (prog_go) begin
            pbuf <= lbuf;
        end
    end

    // registered page read port
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            page_byte_o <= 8'h00;
            page_keep_o <= 1'b0;
        end else begin
            page_byte_o <= pbuf[page_idx_i];
            page_keep_o <= pmask[page_idx_i];
        end
    end

    // status words built from flops
    always_comb begin
        status_o = 8'h00;
        status_o[fpes_pkg::SR_WIP] = busy;
        status_o[fpes_pkg::SR_WEL] = wel;
        flags_o = 8'h00;
        flags_o[fpes_pkg::FSR_READY] = !busy;
        flags_o[fpes_pkg::FSR_PROT]  = prot_err;
        flags_o[fpes_pkg::FSR_PGM]   = pgm_err;
        flags_o[fpes_pkg::FSR_ERS]   = ers_err;
    end
    assign busy_o        = busy;
    assign suspendable_o = busy;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    wren_sets_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cmd_wren |=> status_o[1])
        else $error("latch not set by enable");
    wrdi_clears_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        cmd_wrdi && !cmd_wren |=> !status_o[1])
        else $error("latch not cleared by disable");
    start_busy_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        prog_go |=> op_start_o && busy_o && !status_o[1])
        else $error("program did not start");
    busy_hold_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        op_start_o |-> status_o[0] [*8])
        else $error("busy flag dropped early");
    prot_prog_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        prot_hit && prog_req |=> flags_o[1] && flags_o[4] && status_o[1] && !busy_o)
        else $error("locked program mishandled");
    prot_erase_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        prot_hit && erase_req |=> flags_o[1] && flags_o[5] && status_o[1] && !busy_o)
        else $error("locked erase mishandled");
    pgm_timeout_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        done && array_fail_i && op_o.kind == fpes_pkg::OPK_PROG |=> flags_o[4] && !status_o[1])
        else $error("program timeout not flagged");
    ers_timeout_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        done && array_fail_i && op_o.kind != fpes_pkg::OPK_PROG |=> flags_o[5] && !status_o[1])
        else $error("erase timeout not flagged");
    erase_nowel_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        frame_end && is_erase && !wel && !busy && !flag_clear_i |=>
            !op_start_o && $stable(flags_o))
        else $error("erase without latch acted");
    offbyte_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        frame_end && !byte_ok && !busy |=> !op_start_o && $stable(status_o))
        else $error("broken frame executed");
    done_idle_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        done |=> !status_o[0] && flags_o[7])
        else $error("busy not cleared at completion");
endmodule

/* File: tb/fpes_host_model.sv */
// serial host model: sends frames msb first on one, two or four lines
`timescale 1ns/100ps
module fpes_host_model (
    // link pins
    output logic       sclk_o,
    output logic       cs_n_o,
    output logic [3:0] dq_o
);
    logic [7:0] q[$];  // bytes of the next frame
    int         wl[3] = '{1, 1, 1}; // lanes for opcode, address and data bytes
    ////////////////////////////////////////////////////////////
    // idle: clock stands low, lines never hold a stale bit
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        dq_o   = 4'hA;
    end
    // cut drops trailing bit groups so select rises off a byte
    task automatic send(input int cut);
        int         w;
        logic [3:0] d;
        cs_n_o = 1'b0;
        for (int b = 0; b < q.size(); b++) begin
            w = (b == 0) ? wl[0] : (b < 4) ? wl[1] : wl[2];
            for (int i = 8 - w; i >= 0; i -= w) begin
                if (b + 1 < q.size() || i >= cut) begin
                    d = ~dq_o;
                    for (int j = 0; j < w; j++) d[j] = q[b][i + j];
                    dq_o = d;
                    #15 sclk_o = 1'b1;
                    #15 sclk_o = 1'b0;
                end
            end
        end
        #15 cs_n_o = 1'b1;
        dq_o = ~dq_o;
        q.delete();
        #150;
    endtask
endmodule

/* File: tb/fpes_seq_tb_top.sv */
// self-checking bench of the program/erase sequencer
`timescale 1ns/100ps
module fpes_seq_tb_top;
    logic               core_clk_i, resetn_i, sclk, cs_n, clr_i, fail, busy, susp, start;
    logic               keep;
    logic [3:0]         dq;
    logic [63:0]        lock;
    logic [7:0]         pidx, status, flags, pbyte;
    fpes_pkg::fpes_op_t op;
    fpes_pkg::fpes_proto_t proto;
    int                 n_fail, checks, n_start;
    // host side of the link
    fpes_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .dq_o(dq));
    // durations shortened to 40 core cycles
    fpes_seq #(.PROGRAM_DURATION_US(1), .SMALL_BLOCK_ERASE_DURATION_US(1),
        .BLOCK_ERASE_DURATION_US(1)) DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .dq_i(dq), .proto_i(proto),
        .lock_sector_i(lock), .flag_clear_i(clr_i), .array_fail_i(fail),
        .page_idx_i(pidx), .status_o(status), .flags_o(flags), .busy_o(busy),
        .suspendable_o(susp), .op_start_o(start), .op_o(op), .page_byte_o(pbyte),
        .page_keep_o(keep));
    ////////////////////////////////////////////////////////////
    // count start pulses, since each stands one cycle only
    always @(posedge core_clk_i) begin
        if (!resetn_i) n_start <= 0;
        else if (start === 1'b1) n_start <= n_start + 1;
    end
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    // inputs move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    // frame then 8 cycles, past the 3 to 4 edge answer
    task automatic go(input int cut);
        host.send(cut);
        tick(8);
    endtask
    task automatic cmd(input logic [7:0] c);
        host.q = '{c};
        go(0);
    endtask
    // opcode, address, n data bytes of k xor 5Ah
    task automatic frm(input logic [7:0] c, input logic [23:0] a, input int n, input int cut);
        host.q = '{c, a[23:16], a[15:8], a[7:0]};
        for (int k = 0; k < n; k++) host.q.push_back(k[7:0] ^ 8'h5A);
        go(cut);
    endtask
    // an unwritten column has no defined byte: keep flag only
    task automatic pg(input logic [7:0] col, input logic [8:0] exp);
        pidx = col;
        tick(2);
        chk(exp[8] ? {keep, pbyte} : {keep, 8'h00}, exp);
    endtask
    task automatic clr();
        clr_i = 1'b1;
        tick(1);
        clr_i = 1'b0;
        chk(flags, 8'h80);
    endtask
    // bounded wait for completion, then flags and latch
    task automatic idle(input logic [7:0] fl);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) tick(1);
        chk({status, flags}, {8'h00, fl});
        clr();
    endtask
    task automatic t_latch();
        cmd(fpes_pkg::OP_WREN);
        chk(status, 8'h02);
        cmd(fpes_pkg::OP_WRDI);
        chk(status, 8'h00);
        host.q = '{fpes_pkg::OP_WREN};
        go(3);
        chk(status, 8'h00);
        cmd(fpes_pkg::OP_WREN);
        host.q = '{fpes_pkg::OP_WRDI};
        go(1);
        chk(status, 8'h02);
        cmd(fpes_pkg::OP_WRDI);
        frm(fpes_pkg::OP_SE_DEF, 24'h050000, 0, 0);
        chk({n_start[7:0], flags, status}, 24'h008000);
    endtask
    task automatic t_prog();
        fail = 1'b1;
        cmd(fpes_pkg::OP_WREN);
        frm(fpes_pkg::OP_PP_DEF, 24'h0312FE, 258, 4);
        chk({n_start[7:0], status}, 16'h0002);
        frm(fpes_pkg::OP_PP_DEF, 24'h0312FE, 258, 0);
        chk({n_start[7:0], status, flags, susp, busy}, {8'h01, 8'h01, 8'h00, 2'h3});
        chk(op, {fpes_pkg::OPK_PROG, 24'h0312FE});
        pg(8'hFE, 9'h15A);
        pg(8'hFF, 9'h15B);
        pg(8'h00, 9'h158);
        idle(8'h90);
        fail = 1'b0;
        cmd(fpes_pkg::OP_WREN);
        frm(fpes_pkg::OP_PP_DEF, 24'h0312F0, 1, 0);
        pg(8'hF0, 9'h15A);
        pg(8'hF1, 9'h000);
        idle(8'h80);
    endtask
    task automatic t_erase();
        lock = 64'h8;
        cmd(fpes_pkg::OP_WREN);
        frm(fpes_pkg::OP_SE_DEF, 24'h031234, 0, 0);
        chk({flags, status}, 16'hA202);
        frm(fpes_pkg::OP_PP_DEF, 24'h030000, 1, 0);
        chk({flags, status}, 16'hB202);
        clr();
        lock = 64'h0;
        fail = 1'b1;
        frm(fpes_pkg::OP_SSE_DEF, 24'h041ABC, 0, 0);
        chk({op, susp}, {fpes_pkg::OPK_SSE, 24'h041ABC, 1'b1});
        idle(8'hA0);
        fail = 1'b0;
        cmd(fpes_pkg::OP_WREN);
        frm(fpes_pkg::OP_SE_DEF, 24'h07FFFF, 0, 0);
        chk({n_start[7:0], op}, {8'h04, fpes_pkg::OPK_SE, 24'h07FFFF});
        idle(8'h80);
    endtask
    // switch protocol; a three-edge off-byte frame lets the link see it
    task automatic t_proto(input fpes_pkg::fpes_proto_t p);
        proto = p;
        host.wl = '{1, 1, 1};
        host.q = '{8'h00};
        go(5);
    endtask
    // quad frames, a dual variant refused in quad, extended dual in ext
    task automatic t_lanes();
        t_proto(fpes_pkg::PROTO_QUAD);
        host.wl = '{4, 4, 4};
        cmd(fpes_pkg::OP_WREN);
        chk(status, 8'h02);
        frm(fpes_pkg::OP_QP_DEF, 24'h0100A0, 1, 0);
        pg(8'hA0, 9'h15A);
        idle(8'h80);
        cmd(fpes_pkg::OP_WREN);
        host.wl = '{4, 4, 2};
        frm(fpes_pkg::OP_DP_DEF, 24'h0100A0, 1, 0);
        chk({n_start[7:0], status}, 16'h0502);
        t_proto(fpes_pkg::PROTO_EXT);
        host.wl = '{1, 2, 2};
        frm(fpes_pkg::OP_DPX_DEF, 24'h0200C0, 2, 0);
        pg(8'hC1, 9'h15B);
        idle(8'h80);
    endtask
    task automatic print_verdict();
        if (n_fail == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // watchdog at 2 ms, well past the roughly 150 microseconds needed
    initial begin
        #2000000;
        n_fail++;
        print_verdict();
    end
    initial begin
        {resetn_i, clr_i, fail, lock, pidx, n_fail, checks} = '0;
        proto = fpes_pkg::PROTO_EXT;
        tick(6);
        chk({status, flags}, 16'h0080);
        resetn_i = 1'b1;
        tick(1);
        t_latch();
        t_prog();
        t_erase();
        t_lanes();
        print_verdict();
    end
endmodule
